// ---- design/gpm_monitor.sv ----
`timescale 1ns/100ps

// Contract
// - Alarm follows threshold condition immediately.
// - Each timed feature has own timer from alarm.
// - Timer expiry with alarm gives fault, excitation off; the bus keepalive timer raises only its alarm.
// - Over-excitation clears only below ninety percent.
// - Absorbed reactive power over threshold alarms, faults.
// - Over-voltage alarms and faults after timer.
// - Under-voltage alarms and faults after timer.
// - Phase deviation from average flags imbalance.
// - Imbalance off in single-phase, field-current modes.
// - Reverse power alarms and faults after timer.
// - Lost sensing faults directly, no alarm.
// - Sensing loss armed after 850 RPM, or at once in field-current mode.
// - Field current over 11 A faults directly.
// - Temperature alarm level, separate shutdown level.
// - Reactive or power-factor start, contact open: fault.
// - Below knee: alarm and volts-per-hertz roll-off.
// - Below 25 Hz: no excitation, no metering.
// - No frequency above 850 RPM forces current limit.
// - Base slope from knee band, times multiplier.
// - Field current clamped at limit, alarm raised.
// - Power limiter trims voltage, raises alarm.
// - Missing keepalive within threshold raises bus alarm.
module gpm_monitor
	import gpm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter logic [7:0] TEMP_ALARM_C = 8'h55,
	parameter logic [7:0] TEMP_SHUT_C = 8'h5F
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire gpm_mode_t mode,
	input wire logic [15:0] ifield_ma,
	input wire logic [15:0] oe_thr_ma,
	input wire logic [DUR_W-1:0] oe_dur,
	input wire logic [15:0] q_abs,
	input wire logic [15:0] ue_thr,
	input wire logic [DUR_W-1:0] ue_dur,
	input wire logic [15:0] v_gen,
	input wire logic [15:0] ov_thr,
	input wire logic [DUR_W-1:0] ov_dur,
	input wire logic [15:0] uv_thr,
	input wire logic [DUR_W-1:0] uv_dur,
	input wire logic [15:0] v_a,
	input wire logic [15:0] v_b,
	input wire logic [15:0] v_c,
	input wire logic [15:0] imb_thr,
	input wire logic [DUR_W-1:0] imb_dur,
	input wire logic [15:0] p_rev,
	input wire logic [15:0] rp_thr,
	input wire logic [DUR_W-1:0] rp_dur,
	input wire logic sense_lost,
	input wire logic [15:0] speed_rpm,
	input wire logic [7:0] temp_c,
	input wire logic gen_start,
	input wire logic reactive_pf_disable_contact,
	input wire logic [9:0] freq_dhz,
	input wire logic freq_valid,
	input wire logic [9:0] knee_dhz,
	input wire logic [7:0] slope_mult,
	input wire logic [15:0] if_demand_ma,
	input wire logic [15:0] if_limit_ma,
	input wire logic pwr_lim_en,
	input wire logic [15:0] p_out,
	input wire logic [15:0] p_limit,
	input wire logic regulator_keepalive_message,
	input wire logic [DUR_W-1:0] bus_dur,
	output logic [NALARM-1:0] alarm_q,
	output logic [NFAULT-1:0] fault_q,
	output logic fault_any_q,
	output logic exc_on_q,
	output logic [15:0] field_cmd_q,
	output logic [15:0] per_unit_voltage_q,
	output logic metering_on_q,
	output logic short_circuit_q
);

	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	logic [TW-1:0] tick_cnt_q;
	logic tick_q;
	logic oe_act_q;
	logic speed_seen_q;
	logic [15:0] pwr_trim_q;
	logic [NTIMER-1:0] cond;
	logic [NTIMER-1:0] expired;
	logic [DUR_W-1:0] dur [NTIMER];
	logic oe_act_d;
	logic imb_en;
	logic imb_hit;
	logic [17:0] ph_sum;
	logic [17:0] imb_lim;
	logic los_en;
	logic short_d;
	logic low_freq_d;
	logic exc_on_d;
	logic pwr_hit;
	logic [NFAULT-1:0] fault_d;
	logic [NALARM-1:0] alarm_d;
	logic [15:0] field_cmd_d;
	logic [16:0] slope_recip;
	logic [9:0] freq_drop;
	logic [34:0] rolloff;
	logic [15:0] setpt_uf;
	logic [15:0] setpt_d;

	// ======================================================================
	// Timer time base, one tick per timer resolution step.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (ce)
		begin
			tick_q <= (tick_cnt_q == TW'(TICK_CYCLES - 1));
			if (tick_cnt_q == TW'(TICK_CYCLES - 1))
				tick_cnt_q <= '0;
			else
				tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// ======================================================================
	// Threshold conditions.
	function automatic logic phase_off(input logic [15:0] v, input logic [17:0] sum,
		input logic [17:0] lim);
		logic [17:0] tv;
		tv = {1'b0, v, 1'b0} + {2'b00, v};
		return (tv > sum) ? ((tv - sum) > lim) : ((sum - tv) > lim);
	endfunction

	always_comb
	begin
		oe_act_d = (ifield_ma > oe_thr_ma) || (oe_act_q &&
			(({4'h0, ifield_ma} * OE_CLR_DEN) >= ({4'h0, oe_thr_ma} * OE_CLR_NUM)));
		imb_en = (mode == three_phase_voltage_mode) || (mode == reactive_power_mode) ||
			(mode == power_factor_mode);
		ph_sum = {2'b00, v_a} + {2'b00, v_b} + {2'b00, v_c};
		imb_lim = {1'b0, imb_thr, 1'b0} + {2'b00, imb_thr};
		imb_hit = phase_off(v_a, ph_sum, imb_lim) || phase_off(v_b, ph_sum, imb_lim) ||
			phase_off(v_c, ph_sum, imb_lim);
		cond[F_OVEREXC] = oe_act_d;
		cond[F_UNDEREXC] = q_abs > ue_thr;
		cond[F_OVERVOLT] = v_gen > ov_thr;
		cond[F_UNDERVOLT] = v_gen < uv_thr;
		cond[F_IMBAL] = imb_en && imb_hit;
		cond[F_REVPWR] = p_rev > rp_thr;
		cond[TMR_CAN] = !regulator_keepalive_message;
	end

	assign dur[F_OVEREXC] = oe_dur;
	assign dur[F_UNDEREXC] = ue_dur;
	assign dur[F_OVERVOLT] = ov_dur;
	assign dur[F_UNDERVOLT] = uv_dur;
	assign dur[F_IMBAL] = imb_dur;
	assign dur[F_REVPWR] = rp_dur;
	assign dur[TMR_CAN] = bus_dur;

	genvar gi;
	generate
		for (gi = 0; gi < NTIMER; gi++)
		begin : g_tmr
			gpm_alarm_timer u_tmr (
				.clk(clk),
				.arst_n(arst_n),
				.ce(ce),
				.tick(tick_q),
				.cond(cond[gi]),
				.dur(dur[gi]),
				.expired_q(expired[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			oe_act_q <= 1'b0;
			speed_seen_q <= 1'b0;
		end
		else if (ce)
		begin
			oe_act_q <= oe_act_d;
			if (speed_rpm >= LOS_SPEED_RPM)
				speed_seen_q <= 1'b1;
		end
	end

	// ======================================================================
	// Frequency handling and volts-per-hertz roll-off.
	always_comb
	begin
		short_d = !freq_valid && (speed_rpm > LOS_SPEED_RPM);
		low_freq_d = freq_valid ? (freq_dhz < EXC_CUTOFF_DHZ) : !short_d;
		if (knee_dhz <= KNEE_BAND_A_DHZ)
			slope_recip = SLOPE_RECIP_A;
		else if (knee_dhz <= KNEE_BAND_B_DHZ)
			slope_recip = SLOPE_RECIP_B;
		else
			slope_recip = SLOPE_RECIP_C;
		freq_drop = (freq_valid && (freq_dhz < knee_dhz)) ? (knee_dhz - freq_dhz) : '0;
		rolloff = {25'h0, freq_drop} * {27'h0, slope_mult} * {18'h0, slope_recip};
		if (rolloff[34:16] >= {3'h0, SETPT_UNITY})
			setpt_uf = '0;
		else
			setpt_uf = SETPT_UNITY - rolloff[31:16];
		setpt_d = (setpt_uf > pwr_trim_q) ? (setpt_uf - pwr_trim_q) : '0;
	end

	// ======================================================================
	// Power limiter trim, stepped once per tick.
	assign pwr_hit = pwr_lim_en && (p_out >= p_limit);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pwr_trim_q <= '0;
		else if (ce)
		begin
			if (!pwr_lim_en)
				pwr_trim_q <= '0;
			else if (tick_q && pwr_hit && (pwr_trim_q <= (SETPT_UNITY - PWR_TRIM_STEP)))
				pwr_trim_q <= pwr_trim_q + PWR_TRIM_STEP;
			else if (tick_q && !pwr_hit && (p_out < p_limit))
				pwr_trim_q <= (pwr_trim_q > PWR_TRIM_STEP) ? (pwr_trim_q - PWR_TRIM_STEP) : '0;
		end
	end

	// ======================================================================
	// Fault latch and excitation control.
	always_comb
	begin
		los_en = (mode == field_current_mode) || speed_seen_q;
		fault_d = fault_q;
		for (int i = 0; i < F_LOSS_SENSE; i++)
		begin
			if (expired[i])
				fault_d[i] = 1'b1;
		end
		if (sense_lost && los_en)
			fault_d[F_LOSS_SENSE] = 1'b1;
		if (ifield_ma > IOC_LIMIT_MA)
			fault_d[F_IOC] = 1'b1;
		if (temp_c > TEMP_SHUT_C)
			fault_d[F_OVERTEMP] = 1'b1;
		if (gen_start && reactive_pf_disable_contact &&
			((mode == reactive_power_mode) || (mode == power_factor_mode)))
			fault_d[F_STARTUP] = 1'b1;
		exc_on_d = !(|fault_d) && !low_freq_d;
		if (!exc_on_d)
			field_cmd_d = '0;
		else if (short_d || (if_demand_ma > if_limit_ma))
			field_cmd_d = if_limit_ma;
		else
			field_cmd_d = if_demand_ma;
	end

	always_comb
	begin
		alarm_d = '0;
		alarm_d[A_REVPWR:A_OVEREXC] = cond[F_REVPWR:F_OVEREXC];
		alarm_d[A_OVERTEMP] = temp_c > TEMP_ALARM_C;
		alarm_d[A_UNDERFREQ] = freq_valid && (freq_dhz < knee_dhz);
		alarm_d[A_FIELD_LIM] = short_d || (if_demand_ma > if_limit_ma);
		alarm_d[A_PWR_LIM] = pwr_hit;
		alarm_d[A_BUS_LOSS] = expired[TMR_CAN];
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alarm_q <= '0;
			fault_q <= '0;
			fault_any_q <= 1'b0;
			exc_on_q <= 1'b0;
			field_cmd_q <= '0;
			per_unit_voltage_q <= '0;
			metering_on_q <= 1'b0;
			short_circuit_q <= 1'b0;
		end
		else if (ce)
		begin
			alarm_q <= alarm_d;
			fault_q <= fault_d;
			fault_any_q <= |fault_d;
			exc_on_q <= exc_on_d;
			field_cmd_q <= field_cmd_d;
			per_unit_voltage_q <= setpt_d;
			metering_on_q <= freq_valid && (freq_dhz >= EXC_CUTOFF_DHZ);
			short_circuit_q <= short_d;
		end
	end

	// ======================================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	a_fault_holds: assert property ($rose(fault_any_q) |-> fault_any_q [*8])
		else $error("latched fault dropped");
	a_fault_exc_off: assert property (fault_any_q |-> !exc_on_q && (field_cmd_q == '0))
		else $error("excitation on while faulted");
	a_ioc_trip: assert property ((ce && (ifield_ma > IOC_LIMIT_MA)) |=> fault_q[F_IOC])
		else $error("instantaneous overcurrent fault missing");
	a_ov_alarm: assert property ((ce && (v_gen > ov_thr)) |=> alarm_q[A_OVERVOLT])
		else $error("over-voltage alarm missing");
	a_low_freq_off: assert property ((ce && freq_valid && (freq_dhz < EXC_CUTOFF_DHZ))
		|=> !exc_on_q && !metering_on_q)
		else $error("excitation or metering active below cutoff");
	a_imb_disabled: assert property ((ce && ((mode == single_phase_voltage_mode) ||
		(mode == field_current_mode))) |=> !alarm_q[A_IMBAL])
		else $error("imbalance alarm in disabled mode");
	a_field_clamp: assert property (ce |=> (field_cmd_q <= $past(if_limit_ma)))
		else $error("field command above limit");
	a_los_gated: assert property ((ce && !speed_seen_q && (mode != field_current_mode) &&
		!fault_q[F_LOSS_SENSE]) |=> !fault_q[F_LOSS_SENSE])
		else $error("sensing loss fault before speed seen");
	a_short_limit: assert property ((ce && short_d && !(|fault_d))
		|=> field_cmd_q == $past(if_limit_ma))
		else $error("short circuit did not force field limit");
	a_start_fault: assert property ((ce && gen_start && reactive_pf_disable_contact &&
		(mode == power_factor_mode)) |=> fault_q[F_STARTUP])
		else $error("start-up fault missing");

endmodule // gpm_monitor

// ---- design/gpm_pkg.sv ----
package gpm_pkg;

	// ======================================================================
	// Regulation modes
	typedef enum logic [2:0] {
		three_phase_voltage_mode,
		single_phase_voltage_mode,
		field_current_mode,
		reactive_power_mode,
		power_factor_mode
	} gpm_mode_t;

	// ======================================================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int TIMER_RES_MS = 100;
	localparam int TICK_CYCLES_DEF = TIMER_RES_MS * (CLK_HZ / 1000);
	localparam int DUR_W = 9;

	// ======================================================================
	// Fixed protection levels (field current in mA, speed in RPM, freq in 0.1 Hz)
	localparam logic [15:0] IOC_LIMIT_MA = 16'h2AF8;
	localparam logic [15:0] LOS_SPEED_RPM = 16'h0352;
	localparam logic [9:0] EXC_CUTOFF_DHZ = 10'h0FA;
	localparam logic [3:0] OE_CLR_NUM = 4'h9;
	localparam logic [3:0] OE_CLR_DEN = 4'hA;

	// ======================================================================
	// Volts-per-hertz slopes; one per unit of set point is SETPT_UNITY.
	localparam logic [9:0] KNEE_BAND_A_DHZ = 10'h1F4;
	localparam logic [9:0] KNEE_BAND_B_DHZ = 10'h258;
	localparam longint SLOPE_SCALE = 64'h0000_0001_0000_0000;
	localparam longint SLOPE_UNIT_DIV = 1000;
	localparam longint SLOPE_DEN_A = 50;
	localparam longint SLOPE_DEN_B = 60;
	localparam longint SLOPE_DEN_C = 70;
	localparam logic [16:0] SLOPE_RECIP_A = 17'(SLOPE_SCALE / (SLOPE_UNIT_DIV * SLOPE_DEN_A));
	localparam logic [16:0] SLOPE_RECIP_B = 17'(SLOPE_SCALE / (SLOPE_UNIT_DIV * SLOPE_DEN_B));
	localparam logic [16:0] SLOPE_RECIP_C = 17'(SLOPE_SCALE / (SLOPE_UNIT_DIV * SLOPE_DEN_C));
	localparam logic [15:0] SETPT_UNITY = 16'hFFFF;
	localparam logic [15:0] PWR_TRIM_STEP = 16'h0040;

	// ======================================================================
	// Vector layouts
	localparam int NTIMER = 7;
	localparam int TMR_CAN = 6;
	localparam int NFAULT = 10;
	localparam int F_OVEREXC = 0;
	localparam int F_UNDEREXC = 1;
	localparam int F_OVERVOLT = 2;
	localparam int F_UNDERVOLT = 3;
	localparam int F_IMBAL = 4;
	localparam int F_REVPWR = 5;
	localparam int F_LOSS_SENSE = 6;
	localparam int F_IOC = 7;
	localparam int F_OVERTEMP = 8;
	localparam int F_STARTUP = 9;
	localparam int NALARM = 11;
	localparam int A_OVEREXC = 0;
	localparam int A_UNDEREXC = 1;
	localparam int A_OVERVOLT = 2;
	localparam int A_UNDERVOLT = 3;
	localparam int A_IMBAL = 4;
	localparam int A_REVPWR = 5;
	localparam int A_OVERTEMP = 6;
	localparam int A_UNDERFREQ = 7;
	localparam int A_FIELD_LIM = 8;
	localparam int A_PWR_LIM = 9;
	localparam int A_BUS_LOSS = 10;

endpackage

// ---- design/gpm_alarm_timer.sv ----
`timescale 1ns/100ps

module gpm_alarm_timer
	import gpm_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic cond,
	input wire logic [DUR_W-1:0] dur,
	output logic expired_q
);

	logic [DUR_W-1:0] cnt_q;

	// ======================================================================
	// Tick counter, restarted whenever the condition drops.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= '0;
		else if (ce)
		begin
			if (!cond)
				cnt_q <= '0;
			else if (tick && (cnt_q < dur))
				cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			expired_q <= 1'b0;
		else if (ce)
			expired_q <= cond && (cnt_q >= dur);
	end

	// ======================================================================
	// Checks
	sequence s_held;
		ce && cond;
	endsequence

	a_timer_clear: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && !cond) |=> (cnt_q == '0) && !expired_q)
		else $error("timer not cleared when condition dropped");
	a_timer_step: assert property (@(posedge clk) disable iff (!arst_n)
		(s_held ##0 (tick && (cnt_q < dur))) |=> (cnt_q == $past(cnt_q) + 1))
		else $error("timer did not advance on tick");
	a_timer_expiry: assert property (@(posedge clk) disable iff (!arst_n)
		(s_held ##0 (cnt_q >= dur)) |=> expired_q)
		else $error("timer expiry not flagged");

endmodule // gpm_alarm_timer

// ---- bench/gpm_front_end.sv ----
`timescale 1ns/100ps

// ========
// Sensing front end and excitation stage facing the monitor.
module gpm_front_end
	import gpm_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic exc_on_q,
	input wire logic [15:0] ifield_set,
	input wire logic hb_en,
	input wire logic [7:0] hb_period,
	output logic [15:0] ifield_ma,
	output logic regulator_keepalive_message
);
	logic [7:0] hb_cnt_q;

	// With excitation removed the field current collapses to zero.
	assign ifield_ma = exc_on_q ? ifield_set : 16'h0000;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hb_cnt_q <= 8'h00;
			regulator_keepalive_message <= 1'b0;
		end
		else
		begin
			regulator_keepalive_message <= hb_en && (hb_cnt_q == 8'h00);
			hb_cnt_q <= (hb_cnt_q + 8'h01 >= hb_period) ? 8'h00 : hb_cnt_q + 8'h01;
		end
	end
endmodule // gpm_front_end

// ---- bench/gpm_monitor_bench.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %0h, expected %0h", $time, (a), (e)); end end

module gpm_monitor_bench
	import gpm_pkg::*;
;
	localparam int TICK = 10;
	localparam int LIMIT = 3000;
	logic clk, arst_n = 1'b0, ce = 1'b1;
	gpm_mode_t mode = three_phase_voltage_mode;
	logic [DUR_W-1:0] dur = 9'h003;
	logic [15:0] ifield_set, q_abs, v_gen, v_a, p_rev, speed_rpm, if_demand_ma, p_out;
	logic [15:0] oe_thr_ma = 16'h03E8, ue_thr = 16'h0064, ov_thr = 16'h044C, uv_thr = 16'h0384;
	logic [15:0] v_b = 16'h03E8, v_c = 16'h03E8, imb_thr = 16'h0064, rp_thr = 16'h0064;
	logic [15:0] if_limit_ma = 16'h07D0, p_limit = 16'h03E8, ifield_ma;
	logic [9:0] freq_dhz, knee_dhz;
	logic [7:0] temp_c, slope_mult;
	logic sense_lost, gen_start, reactive_pf_disable_contact, freq_valid, pwr_lim_en, hb_en;
	logic regulator_keepalive_message, fault_any_q, exc_on_q, metering_on_q, short_circuit_q;
	logic [NALARM-1:0] alarm_q;
	logic [NFAULT-1:0] fault_q;
	logic [15:0] field_cmd_q, per_unit_voltage_q;
	int miscompares = 0, n_compared = 0, cycles = 0;

	gpm_monitor #(.TICK_CYCLES(TICK)) dut_u (.clk, .arst_n, .ce, .mode, .ifield_ma, .oe_thr_ma,
		.oe_dur(dur), .q_abs, .ue_thr, .ue_dur(dur), .v_gen, .ov_thr, .ov_dur(dur), .uv_thr,
		.uv_dur(dur), .v_a, .v_b, .v_c, .imb_thr, .imb_dur(dur), .p_rev, .rp_thr, .rp_dur(dur),
		.sense_lost, .speed_rpm, .temp_c, .gen_start, .reactive_pf_disable_contact, .freq_dhz,
		.freq_valid, .knee_dhz, .slope_mult, .if_demand_ma, .if_limit_ma, .pwr_lim_en, .p_out,
		.p_limit, .regulator_keepalive_message, .bus_dur(dur), .alarm_q, .fault_q, .fault_any_q,
		.exc_on_q, .field_cmd_q, .per_unit_voltage_q, .metering_on_q, .short_circuit_q);
	gpm_front_end partner_u (.clk, .arst_n, .exc_on_q, .ifield_set, .hb_en,
		.hb_period(8'h05), .ifield_ma, .regulator_keepalive_message);

	// ========
	// Clock, run limit and verdict.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			miscompares++;
			summarize();
		end
	end

	task summarize;
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ========
	// Shared drivers.
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task do_reset;
		arst_n = 1'b0;
		mode = three_phase_voltage_mode;
		ifield_set = 16'h0064;
		q_abs = 16'h0000;
		v_gen = 16'h03E8;
		v_a = 16'h03E8;
		p_rev = 16'h0000;
		speed_rpm = 16'h0000;
		if_demand_ma = 16'h03E8;
		p_out = 16'h0000;
		freq_dhz = 10'h258;
		knee_dhz = 10'h1F4;
		temp_c = 8'h19;
		slope_mult = 8'h64;
		sense_lost = 1'b0;
		gen_start = 1'b0;
		reactive_pf_disable_contact = 1'b0;
		freq_valid = 1'b1;
		pwr_lim_en = 1'b0;
		hb_en = 1'b1;
		step(3);
		`CHK(exc_on_q, 1'b0)
		arst_n = 1'b1;
		step(2);
		`CHK(exc_on_q, 1'b1)
	endtask

	// Puts one timed feature into or out of its alarm condition.
	task trip(input int f, input bit on);
		case (f)
			F_OVEREXC: ifield_set = on ? 16'h0BB8 : 16'h0064;
			F_UNDEREXC: q_abs = on ? 16'h00C8 : 16'h0000;
			F_OVERVOLT: v_gen = on ? 16'h04B0 : 16'h03E8;
			F_UNDERVOLT: v_gen = on ? 16'h0320 : 16'h03E8;
			F_IMBAL: v_a = on ? 16'h0514 : 16'h03E8;
			default: p_rev = on ? 16'h00C8 : 16'h0000;
		endcase
	endtask

	// ========
	// Scenarios.
	task timed(input int f);
		int i;
		do_reset();
		trip(f, 1'b1);
		step(2);
		`CHK(alarm_q[f], 1'b1)
		step(TICK);
		trip(f, 1'b0);
		step(3);
		`CHK(alarm_q[f], 1'b0)
		trip(f, 1'b1);
		step(2 * TICK - 2);
		`CHK(fault_q[f], 1'b0)
		for (i = 0; i < 3 * TICK && fault_q[f] !== 1'b1; i++)
			step(1);
		`CHK(fault_q[f], 1'b1)
		`CHK(exc_on_q, 1'b0)
		`CHK(field_cmd_q, 16'h0000)
		trip(f, 1'b0);
		step(3);
		`CHK(fault_q[f], 1'b1)
		`CHK(fault_any_q, 1'b1)
	endtask

	task hyst;
		do_reset();
		ifield_set = 16'h044C;
		step(2);
		`CHK(alarm_q[A_OVEREXC], 1'b1)
		ifield_set = 16'h0385;
		step(2);
		`CHK(alarm_q[A_OVEREXC], 1'b1)
		ifield_set = 16'h0383;
		step(2);
		`CHK(alarm_q[A_OVEREXC], 1'b0)
		`CHK(fault_q, 10'h000)
	endtask

	task imb_modes;
		int m;
		do_reset();
		trip(F_IMBAL, 1'b1);
		for (m = 0; m < 5; m++)
		begin
			mode = gpm_mode_t'(m);
			step(3);
			`CHK(alarm_q[A_IMBAL], 1'(m == 0 || m > 2))
		end
	endtask

	task direct;
		do_reset();
		sense_lost = 1'b1;
		step(5);
		`CHK(fault_q[F_LOSS_SENSE], 1'b0)
		speed_rpm = LOS_SPEED_RPM;
		step(3);
		`CHK(fault_q[F_LOSS_SENSE], 1'b1)
		`CHK(alarm_q, 11'h000)
		do_reset();
		ifield_set = IOC_LIMIT_MA;
		step(3);
		`CHK(fault_q[F_IOC], 1'b0)
		ifield_set = IOC_LIMIT_MA + 16'h0001;
		step(2);
		`CHK(fault_q[F_IOC], 1'b1)
		`CHK(exc_on_q, 1'b0)
		do_reset();
		mode = field_current_mode;
		sense_lost = 1'b1;
		step(2);
		`CHK(fault_q[F_LOSS_SENSE], 1'b1)
	endtask

	task temp_start;
		do_reset();
		temp_c = 8'h56;
		step(2);
		`CHK(alarm_q[A_OVERTEMP], 1'b1)
		`CHK(fault_q[F_OVERTEMP], 1'b0)
		temp_c = 8'h60;
		step(2);
		`CHK(fault_q[F_OVERTEMP], 1'b1)
		do_reset();
		gen_start = 1'b1;
		mode = reactive_power_mode;
		step(2);
		`CHK(fault_q[F_STARTUP], 1'b0)
		reactive_pf_disable_contact = 1'b1;
		mode = three_phase_voltage_mode;
		step(2);
		`CHK(fault_q[F_STARTUP], 1'b0)
		mode = reactive_power_mode;
		step(2);
		`CHK(fault_q[F_STARTUP], 1'b1)
		do_reset();
		reactive_pf_disable_contact = 1'b1;
		gen_start = 1'b1;
		mode = power_factor_mode;
		step(2);
		`CHK(fault_q[F_STARTUP], 1'b1)
	endtask

	task freq_tests;
		logic [16:0] recip [3];
		int k;
		longint red;
		recip = '{SLOPE_RECIP_A, SLOPE_RECIP_B, SLOPE_RECIP_C};
		do_reset();
		for (k = 0; k < 3; k++)
		begin
			knee_dhz = 10'(500 + 100 * k);
			freq_dhz = knee_dhz - 10'h032;
			slope_mult = 8'(100 + 50 * k);
			red = (longint'(50) * slope_mult * recip[k]) >> 16;
			step(3);
			`CHK(per_unit_voltage_q, 16'(64'hFFFF - red))
			`CHK(alarm_q[A_UNDERFREQ], 1'b1)
		end
		freq_dhz = EXC_CUTOFF_DHZ - 10'h001;
		step(2);
		`CHK(exc_on_q, 1'b0)
		`CHK(metering_on_q, 1'b0)
		freq_dhz = EXC_CUTOFF_DHZ;
		step(2);
		`CHK(exc_on_q, 1'b1)
		`CHK(metering_on_q, 1'b1)
		`CHK(short_circuit_q, 1'b0)
		freq_valid = 1'b0;
		speed_rpm = 16'h0384;
		step(2);
		`CHK(short_circuit_q, 1'b1)
		`CHK(field_cmd_q, if_limit_ma)
	endtask

	task limits;
		do_reset();
		if_demand_ma = 16'h0BB8;
		step(2);
		`CHK(field_cmd_q, if_limit_ma)
		`CHK(alarm_q[A_FIELD_LIM], 1'b1)
		if_demand_ma = 16'h05DC;
		step(2);
		`CHK(field_cmd_q, 16'h05DC)
		`CHK(alarm_q[A_FIELD_LIM], 1'b0)
		pwr_lim_en = 1'b1;
		p_out = p_limit;
		step(2 * TICK + 2);
		`CHK(alarm_q[A_PWR_LIM], 1'b1)
		`CHK(per_unit_voltage_q <= SETPT_UNITY - PWR_TRIM_STEP, 1'b1)
		p_out = 16'h0000;
		step(5 * TICK);
		`CHK(per_unit_voltage_q, SETPT_UNITY)
		`CHK(alarm_q[A_PWR_LIM], 1'b0)
	endtask

	task bus_loss;
		do_reset();
		step(8 * TICK);
		`CHK(alarm_q[A_BUS_LOSS], 1'b0)
		hb_en = 1'b0;
		step(2 * TICK);
		`CHK(alarm_q[A_BUS_LOSS], 1'b0)
		step(2 * TICK + 4);
		`CHK(alarm_q[A_BUS_LOSS], 1'b1)
		hb_en = 1'b1;
		step(8);
		`CHK(alarm_q[A_BUS_LOSS], 1'b0)
	endtask

	initial
	begin
		do_reset();
		timed(F_OVEREXC);
		timed(F_UNDEREXC);
		timed(F_OVERVOLT);
		timed(F_UNDERVOLT);
		timed(F_IMBAL);
		timed(F_REVPWR);
		hyst();
		imb_modes();
		direct();
		temp_start();
		freq_tests();
		limits();
		bus_loss();
		summarize();
	end
endmodule // gpm_monitor_bench
